/* src/dps_pkg.sv */
// Package: register map, field layout, reset values and timing for the converter block
package dps_pkg;
	// Register offsets (byte addresses on the plain port)
	localparam logic [7:0] DPS_OFS_Q2     = 8'h55;
	localparam logic [7:0] DPS_OFS_Q3     = 8'h56;
	localparam logic [7:0] DPS_OFS_Q4     = 8'h57;
	localparam logic [7:0] DPS_OFS_Q5     = 8'h58;
	localparam logic [7:0] DPS_OFS_Q6     = 8'h59;
	localparam logic [7:0] DPS_OFS_PERIOD = 8'h5c;
	localparam logic [7:0] DPS_OFS_DELAY  = 8'h5d;
	localparam logic [7:0] DPS_OFS_PW     = 8'h5e;

	// Reset values
	localparam logic [7:0] DPS_RST_PERIOD = 8'hff;
	localparam logic [4:0] DPS_RST_TOFF   = 5'h14;
	localparam logic [7:0] DPS_RST_PW     = 8'h00;

	// Field positions and the minimum period code
	localparam int DPS_PER_FIXED_BIT = 6;
	localparam int DPS_DLY_CAL_BIT   = 7;
	localparam int DPS_DLY_POL_BIT   = 5;
	localparam int DPS_PER_MIN_CODE  = 8'h40;

	// Timing: one tick of 61.035 ns, generated from the 20 ns core clock by a
	// fractional accumulator (phase step in 1/1000 ns units)
	localparam int DPS_CLK_PERIOD_PS = 20000;
	localparam int DPS_TICK_PS       = 61035;
	localparam logic [16:0] DPS_ACC_STEP = 17'(DPS_CLK_PERIOD_PS);
	localparam logic [16:0] DPS_ACC_WRAP = 17'(DPS_TICK_PS);
	localparam logic [7:0]  DPS_TOFF_ADD = 8'h04;

	// Calibration run length in ticks
	localparam logic [7:0] DPS_CAL_TICKS = 8'hff;

	// Sense sample carrying the five transistor currents
	typedef struct packed {
		logic [7:0] q2;
		logic [7:0] q3;
		logic [7:0] q4;
		logic [7:0] q5;
		logic [7:0] q6;
	} dps_sense_t;

	// Register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} dps_bus_t;

	// Saturating subtract, used for the on time and for the offset second current
	function automatic logic [7:0] dps_sat_sub(input logic [7:0] a, input logic [7:0] b);
		dps_sat_sub = (a > b) ? 8'(a - b) : 8'h00;
	endfunction
endpackage

/* src/dps_tick_gen.sv */
// Tick generator: one-cycle pulse every 61.035 ns on average
`timescale 1ns/100ps
`default_nettype none
module dps_tick_gen
	import dps_pkg::*;
(
	// Clock and reset
	input  wire logic i_core_clk,
	input  wire logic i_resetn,
	// Tick
	output logic      o_tick
);
	typedef struct packed {
		logic [16:0] acc;
		logic        tick;
	} dps_tick_state_t;

	dps_tick_state_t state_reg;
	dps_tick_state_t state_next;

	always_comb begin
		state_next = state_reg;
		state_next.tick = 1'b0;
		if (17'(state_reg.acc + DPS_ACC_STEP) >= DPS_ACC_WRAP) begin
			state_next.acc  = 17'(state_reg.acc + DPS_ACC_STEP - DPS_ACC_WRAP);
			state_next.tick = 1'b1;
		end else begin
			state_next.acc = 17'(state_reg.acc + DPS_ACC_STEP);
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_tick = state_reg.tick;
endmodule
`default_nettype wire

/* src/dps_sense_adjust.sv */
// Sense capture: registers the live currents, second one without the extended-feed offset
`timescale 1ns/100ps
`default_nettype none
module dps_sense_adjust
	import dps_pkg::*;
(
	// Clock and reset
	input  wire logic       i_core_clk,
	input  wire logic       i_resetn,
	// Raw measurements
	input  wire dps_sense_t i_sense_raw,
	input  wire logic       i_extended_feed_enable,
	input  wire logic [7:0] i_extended_feed_offset_current,
	// Reported codes
	output dps_sense_t      o_sense
);
	dps_sense_t state_reg;
	dps_sense_t state_next;

	always_comb begin
		state_next = i_sense_raw;
		if (i_extended_feed_enable) begin
			state_next.q2 = dps_sat_sub(i_sense_raw.q2, i_extended_feed_offset_current);
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_sense = state_reg;
endmodule
`default_nettype wire

/* src/dps_top.sv */
// Converter PWM control and line-feed transistor current sense registers
//
// Overview of operation
// - Second current: 8-bit code, .319 mA steps
// - Extended feed on: offset left out
// - Third/fourth currents: 37.6 uA steps
// - Fifth/sixth currents: .316 mA steps
// - Period code sets period in ticks
// - Period bit 6 reads one, unwritable
// - Bit 7 starts calibration, reads busy
// - Read-only polarity bit fixed by variant
// - Off time at least code plus four
// - Pulse width equals on+off+4 ticks
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module dps_top
	import dps_pkg::*;
#(
	parameter logic HAS_CONVERTER = 1'b1,
	parameter logic FF_SAME_POL   = 1'b0
)
(
	// Clock and reset
	input  wire logic       i_core_clk,
	input  wire logic       i_resetn,
	// Register port
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic [7:0]      o_rdata,
	// Current sense
	input  wire dps_sense_t i_sense_raw,
	input  wire logic       i_extended_feed_enable,
	input  wire logic [7:0] i_extended_feed_offset_current,
	// Converter pins
	output logic            o_converter_drive_output,
	output logic            o_feed_forward_output,
	output logic            o_cal_active
);
	typedef enum {ST_ON, ST_OFF} dps_phase_t;

	typedef struct packed {
		logic [7:0] period;
		logic [4:0] toff;
		logic       cal;
		logic [7:0] cal_cnt;
		logic [7:0] pw;
		logic [7:0] tick_cnt;
		logic [7:0] on_len;
		logic       drive;
		logic [7:0] rdata;
	} dps_state_t;

	dps_state_t state_reg;
	dps_state_t state_next;
	dps_sense_t sense;
	logic       tick;
	logic [7:0] off_len;
	logic [7:0] on_calc;
	logic [7:0] period_eff;
	dps_bus_t   bus;

	dps_tick_gen u_tick (
		.i_core_clk (i_core_clk),
		.i_resetn   (i_resetn),
		.o_tick     (tick)
	);

	dps_sense_adjust u_sense (
		.i_core_clk                     (i_core_clk),
		.i_resetn                       (i_resetn),
		.i_sense_raw                    (i_sense_raw),
		.i_extended_feed_enable         (i_extended_feed_enable),
		.i_extended_feed_offset_current (i_extended_feed_offset_current),
		.o_sense                        (sense)
	);

	assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

	always_comb begin
		off_len    = 8'(state_reg.toff) + DPS_TOFF_ADD;
		period_eff = (state_reg.period < 8'(DPS_PER_MIN_CODE)) ? 8'(DPS_PER_MIN_CODE)
			: state_reg.period;
		on_calc    = dps_sat_sub(period_eff, off_len);
	end

	always_comb begin
		state_next = state_reg;
		// Register writes
		if (bus.wr && HAS_CONVERTER) begin
			unique case (bus.addr)
				DPS_OFS_PERIOD: begin
					state_next.period = bus.wdata;
					state_next.period[DPS_PER_FIXED_BIT] = 1'b1;
				end
				DPS_OFS_DELAY: begin
					state_next.toff = bus.wdata[4:0];
					if (bus.wdata[DPS_DLY_CAL_BIT] && !state_reg.cal) begin
						state_next.cal     = 1'b1;
						state_next.cal_cnt = DPS_CAL_TICKS;
					end
				end
				default: begin
				end
			endcase
		end
		// Calibration runs a fixed number of ticks with the drive held off
		if (state_reg.cal && tick) begin
			if (state_reg.cal_cnt == 8'h00) begin
				state_next.cal = 1'b0;
			end else begin
				state_next.cal_cnt = 8'(state_reg.cal_cnt - 8'h01);
			end
		end
		// PWM: count ticks over one period, drive on for the on part
		// The next calibration state is used so the drive drops in the same cycle that
		// calibration starts, never leaving one cycle of drive beside a busy flag
		if (!HAS_CONVERTER || state_next.cal) begin
			state_next.drive    = 1'b0;
			state_next.tick_cnt = 8'h00;
		end else if (tick) begin
			if (state_reg.tick_cnt >= 8'(period_eff - 8'h01)) begin
				state_next.tick_cnt = 8'h00;
				state_next.on_len   = on_calc;
				state_next.drive    = (on_calc != 8'h00);
				state_next.pw       = 8'(on_calc + off_len);
			end else begin
				state_next.tick_cnt = 8'(state_reg.tick_cnt + 8'h01);
				if (8'(state_reg.tick_cnt + 8'h01) >= state_reg.on_len) begin
					state_next.drive = 1'b0;
				end
			end
		end
		// Read data, valid the cycle after the strobe
		state_next.rdata = 8'h00;
		if (bus.rd) begin
			unique case (bus.addr)
				DPS_OFS_Q2: state_next.rdata = sense.q2;
				DPS_OFS_Q3: state_next.rdata = sense.q3;
				DPS_OFS_Q4: state_next.rdata = sense.q4;
				DPS_OFS_Q5: state_next.rdata = sense.q5;
				DPS_OFS_Q6: state_next.rdata = sense.q6;
				DPS_OFS_PERIOD: state_next.rdata = HAS_CONVERTER ? state_reg.period : 8'h00;
				DPS_OFS_DELAY: begin
					if (HAS_CONVERTER) begin
						state_next.rdata = {state_reg.cal, 1'b0, FF_SAME_POL, state_reg.toff};
					end
				end
				DPS_OFS_PW: state_next.rdata = HAS_CONVERTER ? state_reg.pw : 8'h00;
				default: state_next.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_reg        <= '0;
			state_reg.period <= DPS_RST_PERIOD;
			state_reg.toff   <= DPS_RST_TOFF;
			state_reg.pw     <= DPS_RST_PW;
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_rdata                  = state_reg.rdata;
	assign o_converter_drive_output = state_reg.drive;
	// Feed-forward follows drive, inverted unless the same-polarity variant
	assign o_feed_forward_output    = HAS_CONVERTER & (state_reg.drive ^ ~FF_SAME_POL);
	assign o_cal_active             = state_reg.cal;
endmodule
`default_nettype wire

/* test/dps_checker.sv */
// Port checker for the converter register block
`timescale 1ns/100ps
`default_nettype none
module dps_checker
	import dps_pkg::*;
#(
	parameter logic FF_SAME_POL = 1'b0
)
(
	// Clock, reset and register port
	input wire logic       i_core_clk,
	input wire logic       i_resetn,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic [7:0] o_rdata,
	// Sense and converter pins
	input wire dps_sense_t i_sense_raw,
	input wire logic       i_extended_feed_enable,
	input wire logic       o_converter_drive_output,
	input wire logic       o_feed_forward_output,
	input wire logic       o_cal_active
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	property p_q2; $past(i_rd) && $past(i_addr) == DPS_OFS_Q2 && !$past(i_extended_feed_enable, 2)
		|-> o_rdata == $past(i_sense_raw.q2, 2); endproperty
	a_q2: assert property (p_q2) else $error("second current read wrong");
	property p_q3; $past(i_rd) && $past(i_addr) == DPS_OFS_Q3
		|-> o_rdata == $past(i_sense_raw.q3, 2); endproperty
	a_q3: assert property (p_q3) else $error("third current read wrong");
	property p_q6; $past(i_rd) && $past(i_addr) == DPS_OFS_Q6
		|-> o_rdata == $past(i_sense_raw.q6, 2); endproperty
	a_q6: assert property (p_q6) else $error("sixth current read wrong");
	property p_per; $past(i_rd) && $past(i_addr) == DPS_OFS_PERIOD |-> o_rdata[6]; endproperty
	a_per: assert property (p_per) else $error("period bit 6 not one");
	property p_pol; o_feed_forward_output == (o_converter_drive_output ~^ FF_SAME_POL); endproperty
	a_pol: assert property (p_pol) else $error("feed forward polarity wrong");
	property p_cal; i_wr && i_addr == DPS_OFS_DELAY && i_wdata[7] && !o_cal_active
		|=> o_cal_active; endproperty
	a_cal: assert property (p_cal) else $error("calibration did not start");
	property p_cal_off; o_cal_active |-> !o_converter_drive_output; endproperty
	a_cal_off: assert property (p_cal_off) else $error("drive on during calibration");
	property p_off; $fell(o_converter_drive_output) |-> !o_converter_drive_output [*8]; endproperty
	a_off: assert property (p_off) else $error("off time too short");
	property p_on; $rose(o_converter_drive_output) |-> ##[1:800] !o_converter_drive_output;
	endproperty
	a_on: assert property (p_on) else $error("drive never turned off");
	property p_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("read data not zero when idle");
endmodule
bind dps_top dps_checker #(.FF_SAME_POL(FF_SAME_POL)) i_dps_checker (.i_core_clk, .i_resetn,
	.i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_sense_raw, .i_extended_feed_enable,
	.o_converter_drive_output, .o_feed_forward_output, .o_cal_active);
`default_nettype wire

/* test/dps_feed_model.sv */
// Line-feed transistors: currents settle on the clock, switch pulses counted
`timescale 1ns/100ps
`default_nettype none
module dps_feed_model
	import dps_pkg::*;
(
	input  wire logic       i_core_clk,
	input  wire logic       i_gate,
	input  wire dps_sense_t i_level,
	output dps_sense_t      o_sense,
	output int              o_pulses
);
	logic gate_d;
	initial begin
		o_sense = '0;
		o_pulses = 0;
		gate_d = 1'b0;
	end
	always @(posedge i_core_clk) begin
		o_sense <= i_level;
		gate_d <= i_gate;
		if (i_gate && !gate_d) begin
			o_pulses <= o_pulses + 1;
		end
	end
endmodule
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the converter register block
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import dps_pkg::*;
;
	logic       i_core_clk = 1'b0;
	logic       i_resetn   = 1'b0;
	logic [7:0] i_addr     = 8'h00;
	logic [7:0] i_wdata    = 8'h00;
	logic       i_wr       = 1'b0;
	logic       i_rd       = 1'b0;
	logic       i_ef       = 1'b0;
	logic [7:0] i_ofs      = 8'h00;
	dps_sense_t lvl        = '0;
	dps_sense_t sense;
	logic [7:0] o_rdata;
	logic       drive;
	logic       ff;
	logic       cal;
	int         pulses;
	int         n_errors   = 0;
	int         num_checks = 0;
	always #10 i_core_clk = ~i_core_clk;
	dps_feed_model i_dps_feed_model (.i_core_clk, .i_gate(drive), .i_level(lvl), .o_sense(sense),
		.o_pulses(pulses));
	dps_top i_dps_top (.i_core_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.i_sense_raw(sense), .i_extended_feed_enable(i_ef), .i_extended_feed_offset_current(i_ofs),
		.o_converter_drive_output(drive), .o_feed_forward_output(ff), .o_cal_active(cal));
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
		@(posedge i_core_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 chk(what, o_rdata, e);
	endtask
	// Counts cycles until the drive pin reaches v
	task automatic wait_drv(input logic v, output int n);
		n = 0;
		while (drive !== v) begin
			@(posedge i_core_clk);
			#1 n++;
			if (n > 2000) begin
				n_errors++;
				summarize();
			end
		end
	endtask
	task automatic t_reset;
		rd(DPS_OFS_PERIOD, 8'hff, "period");
		rd(DPS_OFS_DELAY, 8'h14, "delay");
		rd(8'h5a, 8'h00, "unmapped");
		$display("test reset done");
	endtask
	task automatic t_sense;
		for (int p = 0; p < 2; p++) begin
			@(posedge i_core_clk);
			lvl <= p ? 40'hff_0001_fe7f : 40'h00_ff01_fe80;
			repeat (3) @(posedge i_core_clk);
			for (int i = 0; i < 5; i++) begin
				rd(DPS_OFS_Q2 + 8'(i), lvl[39 - 8 * i -: 8], "current");
			end
		end
		@(posedge i_core_clk);
		lvl.q2 <= 8'h30;
		i_ef <= 1'b1;
		i_ofs <= 8'h10;
		repeat (3) @(posedge i_core_clk);
		rd(DPS_OFS_Q2, 8'h20, "q2_offset");
		@(posedge i_core_clk);
		i_ofs <= 8'h40;
		repeat (3) @(posedge i_core_clk);
		rd(DPS_OFS_Q2, 8'h00, "q2_floor");
		@(posedge i_core_clk);
		i_ef <= 1'b0;
		$display("test sense done");
	endtask
	task automatic t_period;
		int on;
		int off;
		int e_on;
		int e_off;
		e_on = (8'h40 - 4) * DPS_TICK_PS / DPS_CLK_PERIOD_PS;
		e_off = 4 * DPS_TICK_PS / DPS_CLK_PERIOD_PS;
		wr(DPS_OFS_PERIOD, 8'h00);
		rd(DPS_OFS_PERIOD, 8'h40, "period_low");
		wr(DPS_OFS_PERIOD, 8'hbf);
		rd(DPS_OFS_PERIOD, 8'hff, "period_high");
		wr(DPS_OFS_PERIOD, 8'h40);
		wr(DPS_OFS_DELAY, 8'h00);
		wait_drv(1'b0, on);
		wait_drv(1'b1, on);
		chk("feed_forward", {7'h00, ff}, 8'h00);
		wait_drv(1'b0, on);
		wait_drv(1'b1, off);
		chk("on_time", 8'(on >= e_on - 2 && on <= e_on + 2), 8'h01);
		chk("off_time", 8'(off >= e_off - 2 && off <= e_off + 2), 8'h01);
		// The pulse counter lags the pin by one edge, so it is read after the bus read
		rd(DPS_OFS_PW, 8'h40, "pulse_width");
		chk("pulses", 8'(pulses > 1), 8'h01);
		$display("test period done");
	endtask
	task automatic t_cal;
		wr(DPS_OFS_DELAY, 8'h80);
		rd(DPS_OFS_DELAY, 8'h80, "cal_busy");
		chk("cal_drive", {7'h00, drive}, 8'h00);
		for (int k = 0; k < 1000 && cal !== 1'b0; k++) begin
			@(posedge i_core_clk);
			#1;
		end
		chk("cal_end", {7'h00, cal}, 8'h00);
		rd(DPS_OFS_DELAY, 8'h00, "cal_idle");
		$display("test calibration done");
	endtask
	initial begin
		repeat (2) @(posedge i_core_clk);
		i_resetn <= 1'b1;
		t_reset();
		t_sense();
		t_period();
		t_cal();
		summarize();
	end
endmodule
`default_nettype wire
